/* core/irq_regs_map.vh */
// Register word indices, field positions and reset values of the interrupt request block
// Byte address on the bus is four times the _OFF value; the IDX_ values are not bus addresses
`ifndef IRQ_REGS_MAP_VH
`define IRQ_REGS_MAP_VH

`define PENDING_LOW_OFF     8'hed
`define ENABLE_LOW_OFF      8'he8
`define PENDING_HIGH_OFF    8'hec
`define ENABLE_HIGH_OFF     8'he4
`define MASTER_CTRL_OFF     8'hf0
`define STATUS_OFF          8'hf4
`define CPU_MASK_OFF        8'hf8

`define IDX_PENDING_LOW     3'd0
`define IDX_ENABLE_LOW      3'd1
`define IDX_PENDING_HIGH    3'd2
`define IDX_ENABLE_HIGH     3'd3
`define IDX_MASTER          3'd4
`define IDX_STATUS          3'd5
`define IDX_CPU_MASK        3'd6

`define LOW_USED_MASK       8'hfd
`define RESET_BYTE          8'h00
`define MASTER_EN_BIT       0

`endif

/* core/irq_flag_bit.v */
// One interrupt request flag with set, accept-clear and software write
`timescale 1ns/1ps
module irq_flag_bit (
   // Clock and reset
   input  wire sys_clk_in,
   input  wire rst_b_in,
   // Controls
   input  wire event_in,
   input  wire accept_in,
   input  wire wr_en_in,
   input  wire wr_val_in,
   // State
   output reg  flag_out
);
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flag_out <= 1'b0;
      end else if (event_in) begin
         flag_out <= 1'b1;
      end else if (accept_in) begin
         flag_out <= 1'b0;
      end else if (wr_en_in) begin
         flag_out <= wr_val_in;
      end
   end
endmodule

/* core/irq_status_bits.v */
// Sticky event status bits cleared by writing one
`timescale 1ns/1ps
module irq_status_bits #(
   parameter WIDTH = 16
) (
   // Clock and reset
   input  wire             sys_clk_in,
   input  wire             rst_b_in,
   // Events and clear
   input  wire [WIDTH-1:0] set_in,
   input  wire             clr_en_in,
   input  wire [WIDTH-1:0] clr_in,
   // State
   output reg  [WIDTH-1:0] status_out
);
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         status_out <= {WIDTH{1'b0}};
      end else begin
         status_out <= set_in | (status_out & ~(clr_en_in ? clr_in : {WIDTH{1'b0}}));
      end
   end
endmodule

/* core/irq_enable_request_regs.v */
// Interrupt enable and request flag registers on an AHB-Lite slave
`timescale 1ns/1ps
`include "irq_regs_map.vh"
module irq_enable_request_regs (
   // Clock and reset
   input  wire        sys_clk_in,
   input  wire        rst_b_in,
   // AHB-Lite slave
   input  wire        hsel_in,
   input  wire [9:0]  haddr_in,
   input  wire [1:0]  htrans_in,
   input  wire        hwrite_in,
   input  wire [2:0]  hsize_in,
   input  wire [31:0] hwdata_in,
   input  wire        hready_in,
   output wire [31:0] hrdata_out,
   output wire        hreadyout_out,
   output wire        hresp_out,
   // Peripheral events, high then low group
   input  wire [7:0]  event_high_in,
   input  wire [7:0]  event_low_in,
   // CPU side
   input  wire        cpu_master_en_in,
   input  wire [15:0] accept_in,
   output wire [15:0] cpu_irq_req_out,
   output wire        cpu_irq_out,
   // Summary interrupt
   output wire        irq_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Bus address phase capture
   reg        wr_pend_reg;
   reg        rd_pend_reg;
   reg [7:0]  addr_reg;
   reg [31:0] rdata_reg;
   wire       addr_ok = hsel_in & hready_in & htrans_in[1];

   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end else if (hready_in) begin
         wr_pend_reg <= addr_ok & hwrite_in;
         rd_pend_reg <= addr_ok & ~hwrite_in;
         addr_reg    <= haddr_in[9:2];
      end
   end

   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Write strobes
   wire [7:0] wbyte      = hwdata_in[7:0];
   wire wr_pend_low      = wr_pend_reg & (addr_reg == `PENDING_LOW_OFF);
   wire wr_en_low        = wr_pend_reg & (addr_reg == `ENABLE_LOW_OFF);
   wire wr_pend_high     = wr_pend_reg & (addr_reg == `PENDING_HIGH_OFF);
   wire wr_en_high       = wr_pend_reg & (addr_reg == `ENABLE_HIGH_OFF);
   wire wr_master        = wr_pend_reg & (addr_reg == `MASTER_CTRL_OFF);
   wire wr_status        = wr_pend_reg & (addr_reg == `STATUS_OFF);
   wire wr_mask          = wr_pend_reg & (addr_reg == `CPU_MASK_OFF);

   ////////////////////////////////////////////////////////////////////////////
   // Enable registers, master enable and summary interrupt mask
   reg [7:0]  irq_enable_low_reg;
   reg [7:0]  irq_enable_high_reg;
   reg        master_en_reg;
   reg [15:0] mask_reg;

   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq_enable_low_reg  <= `RESET_BYTE;
         irq_enable_high_reg <= `RESET_BYTE;
         master_en_reg       <= 1'b0;
         mask_reg            <= 16'h0000;
      end else begin
         if (wr_en_low) begin
            irq_enable_low_reg <= wbyte & `LOW_USED_MASK;
         end
         if (wr_en_high) begin
            irq_enable_high_reg <= wbyte;
         end
         if (wr_master) begin
            master_en_reg <= wbyte[`MASTER_EN_BIT];
         end
         if (wr_mask) begin
            mask_reg <= hwdata_in[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request flags, one cell per bit
   wire [15:0] pending;
   wire [15:0] events   = {event_high_in, event_low_in & `LOW_USED_MASK};
   wire [15:0] wr_sel   = {{8{wr_pend_high}}, {8{wr_pend_low}} & `LOW_USED_MASK};
   wire [15:0] wr_vals  = {wbyte, wbyte};
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : flags
         irq_flag_bit u_flag (
            .sys_clk_in (sys_clk_in),
            .rst_b_in   (rst_b_in),
            .event_in   (events[g]),
            .accept_in  (accept_in[g]),
            .wr_en_in   (wr_sel[g]),
            .wr_val_in  (wr_vals[g]),
            .flag_out   (pending[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Requests to the CPU
   wire master_on = master_en_reg & cpu_master_en_in;
   wire [15:0] enabled = {irq_enable_high_reg, irq_enable_low_reg};
   assign cpu_irq_req_out = pending & enabled & {16{master_on}};
   assign cpu_irq_out     = |cpu_irq_req_out;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event status and summary interrupt
   wire [15:0] status;
   irq_status_bits #(
      .WIDTH (16)
   ) u_status (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .set_in     (events),
      .clr_en_in  (wr_status),
      .clr_in     (hwdata_in[15:0]),
      .status_out (status)
   );
   assign irq_out = |(status & mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   reg [31:0] rd_next;
   always @* begin
      case (addr_reg)
         `PENDING_LOW_OFF:  rd_next = {24'h000000, pending[7:0]};
         `ENABLE_LOW_OFF:   rd_next = {24'h000000, irq_enable_low_reg};
         `PENDING_HIGH_OFF: rd_next = {24'h000000, pending[15:8]};
         `ENABLE_HIGH_OFF:  rd_next = {24'h000000, irq_enable_high_reg};
         `MASTER_CTRL_OFF:  rd_next = {31'h00000000, master_en_reg};
         `STATUS_OFF:       rd_next = {16'h0000, status};
         `CPU_MASK_OFF:     rd_next = {16'h0000, mask_reg};
         default:           rd_next = 32'h00000000;
      endcase
   end

   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_reg <= 32'h00000000;
      end else if (addr_ok & ~hwrite_in) begin
         rdata_reg <= 32'h00000000;
      end
   end

   assign hrdata_out = rd_pend_reg ? rd_next : rdata_reg;
endmodule

/* dv/irq_regs_asserts.sv */
// Port checks for the interrupt enable and request block
`timescale 1ns/1ps
module irq_regs_asserts (
   input wire logic        sys_clk_in, rst_b_in, hsel_in, hwrite_in, hready_in,
   input wire logic [9:0]  haddr_in,
   input wire logic [7:0]  event_high_in, event_low_in,
   input wire logic [1:0]  htrans_in,
   input wire logic [2:0]  hsize_in,
   input wire logic [31:0] hwdata_in, hrdata_out,
   input wire logic        hreadyout_out, hresp_out, cpu_master_en_in, cpu_irq_out, irq_out,
   input wire logic [15:0] accept_in, cpu_irq_req_out
);
   logic        rd_q;
   logic        wr_q;
   logic [15:0] acc_q;
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_q  <= 1'b0;
         wr_q  <= 1'b0;
         acc_q <= 16'h0000;
      end else begin
         rd_q  <= hsel_in & hready_in & htrans_in[1] & ~hwrite_in;
         wr_q  <= hsel_in & hready_in & htrans_in[1] & hwrite_in;
         acc_q <= accept_in & ~{event_high_in, event_low_in};
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence quiet_s;
      cpu_master_en_in && accept_in == 16'h0000 && !wr_q;
   endsequence
   chk_master_gate: assert property (!cpu_master_en_in |-> cpu_irq_req_out == 16'h0000)
      else $error("request shown with master enable low");
   chk_req_summary: assert property (cpu_irq_out == (cpu_irq_req_out != 16'h0000))
      else $error("cpu interrupt differs from request summary");
   chk_bit1_unused: assert property (cpu_irq_req_out[1] == 1'b0)
      else $error("unused low bit raised a request");
   chk_accept_clears: assert property (acc_q != 16'h0000 |-> (cpu_irq_req_out & acc_q) == 16'h0000)
      else $error("accepted request still shown");
   chk_req_sticky: assert property (quiet_s ##1 cpu_master_en_in |->
      (cpu_irq_req_out & $past(cpu_irq_req_out)) == $past(cpu_irq_req_out))
      else $error("request dropped without cause");
   chk_irq_sticky: assert property (irq_out && !wr_q |=> irq_out)
      else $error("summary interrupt dropped without write");
   chk_rdata_idle: assert property (!rd_q |-> hrdata_out == 32'h0)
      else $error("read data outside read data phase");
   chk_bus_okay: assert property (hreadyout_out && !hresp_out)
      else $error("bus not ready or not okay");
endmodule
bind irq_enable_request_regs irq_regs_asserts u_chk (.*);

/* dv/irq_source_model.sv */
// Peripheral event and CPU accept pulse source
`timescale 1ns/1ps
module irq_source_model (
   input  wire logic        sys_clk_in,
   input  wire logic [15:0] ev_req_in,
   input  wire logic [15:0] acc_req_in,
   output logic      [15:0] event_out = 16'h0000,
   output logic      [15:0] accept_out = 16'h0000
);
   always @(posedge sys_clk_in) begin
      event_out  <= ev_req_in;
      accept_out <= acc_req_in;
   end
endmodule

/* dv/irq_enable_request_regs_tb.sv */
// Register access and interrupt flow tests
`timescale 1ns/1ps
`include "irq_regs_map.vh"
module irq_enable_request_regs_tb;
   logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, men = 1'b0, hrdy, hresp, cirq, irq;
   logic [9:0]  haddr = 10'h000;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic [15:0] evq = 16'h0, accq = 16'h0, ev, acc, req;
   logic [7:0]  offs [8] = '{`PENDING_LOW_OFF, `ENABLE_LOW_OFF, `PENDING_HIGH_OFF, `ENABLE_HIGH_OFF,
                             `MASTER_CTRL_OFF, `STATUS_OFF, `CPU_MASK_OFF, 8'h10};
   int          err_count = 0, checked = 0;
   always #5 clk = ~clk;
   irq_source_model u_src (.sys_clk_in(clk), .ev_req_in(evq), .acc_req_in(accq), .event_out(ev), .accept_out(acc));
   irq_enable_request_regs u_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
      .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .event_high_in(ev[15:8]),
      .event_low_in(ev[7:0]), .cpu_master_en_in(men), .accept_in(acc), .cpu_irq_req_out(req),
      .cpu_irq_out(cirq), .irq_out(irq));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1; haddr <= {a, 2'b00}; hwrite <= wr; htrans <= 2'h2;
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask
   task automatic pulse(input logic [15:0] e, input logic [15:0] k);
      @(posedge clk); evq <= e; accq <= k;
      @(posedge clk); evq <= 16'h0; accq <= 16'h0;
      repeat (2) @(posedge clk);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #100000; err_count++; $display("watchdog expired"); complete_run;
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      foreach (offs[i]) rdchk(offs[i], 32'h0, "reset value");
      bus(1'b1, `ENABLE_LOW_OFF, 32'hff); rdchk(`ENABLE_LOW_OFF, 32'hfd, "enable low");
      bus(1'b1, `PENDING_LOW_OFF, 32'hff); rdchk(`PENDING_LOW_OFF, 32'hfd, "pending low");
      @(negedge clk); chk("req no master", 32'h0, {16'h0, req});
      bus(1'b1, `MASTER_CTRL_OFF, 32'h1); men <= 1'b1;
      @(negedge clk); chk("req all", 32'hfd, {16'h0, req}); chk("cpu irq", 32'h1, {31'h0, cirq});
      bus(1'b1, `ENABLE_LOW_OFF, 32'h01); @(negedge clk); chk("req basic", 32'h1, {16'h0, req});
      @(posedge clk); men <= 1'b0; @(negedge clk); chk("req gated", 32'h0, {16'h0, req});
      @(posedge clk); men <= 1'b1; $display("test enables done");
      bus(1'b1, `PENDING_LOW_OFF, 32'h0); rdchk(`PENDING_LOW_OFF, 32'h0, "pending low clear");
      bus(1'b1, `ENABLE_HIGH_OFF, 32'hff); pulse(16'h8100, 16'h0);
      rdchk(`PENDING_HIGH_OFF, 32'h81, "timer events");
      @(negedge clk); chk("req timers", 32'h8100, {16'h0, req});
      pulse(16'h0, 16'h8000); rdchk(`PENDING_HIGH_OFF, 32'h01, "accept clear");
      bus(1'b1, `PENDING_HIGH_OFF, 32'h0); rdchk(`PENDING_HIGH_OFF, 32'h0, "sw clear");
      $display("test flags done");
      bus(1'b1, `CPU_MASK_OFF, 32'hffff); pulse(16'h0004, 16'h0);
      @(negedge clk); chk("irq set", 32'h1, {31'h0, irq}); chk("req blocked", 32'h0, {16'h0, req});
      rdchk(`STATUS_OFF, 32'h8104, "status");
      bus(1'b1, `CPU_MASK_OFF, 32'h0); @(negedge clk); chk("irq masked", 32'h0, {31'h0, irq});
      bus(1'b1, `CPU_MASK_OFF, 32'hffff); bus(1'b1, `STATUS_OFF, 32'hffff);
      @(negedge clk); chk("irq cleared", 32'h0, {31'h0, irq}); rdchk(`STATUS_OFF, 32'h0, "status clear");
      $display("test interrupt done");
      complete_run;
   end
endmodule
